/* logic/fmrm_top.sv */
// Control register multiple move engine with AHB-Lite register slave
// Behaviour
// RL1: every selected register moves as one 32-bit long word
// RL2: any subset of control, status, address registers; only selected ones move
// RL3: order is always control, then status, then instruction address
// RL4: unselected registers leave no gap; selected ones use consecutive slots
// RL5: first register at effective address, each next one word higher; the code steps one long word (four bytes) per register
// RL6: predecrement lowers address register by four per register, then ascends
// RL7: postincrement moves from address register, then raises it four per register
// RL8: data register direct legal only with exactly one selected register
// RL9: address register direct legal only for instruction address alone
// RL10: one-register list behaves exactly as the single register move
// RL11: original variant reports no pending exceptions, only protocol violation
// RL12: writing enable or status exception bytes never raises an exception
// RL13: status register changes only when loaded, then wholly replaced
// RL14: memory source accepts modes 2-6 and absolute, immediate, PC forms
// RL15: memory destination rejects immediate and all PC-relative forms
// RL16: direction 0 loads from memory, 1 stores to memory
// RL17: command bits 12, 11, 10 select control, status, instruction address
// RL18: the issuer sets at least one select bit; empty list is illegal
// RL19: operation word: ones, coprocessor id, zeros, effective address fields
// RL20: command word: 10, direction, selects, ten zero bits
//
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "fmrm_consts.svh"
module fmrm_top #(
	parameter logic [2:0] CPID = `FMRM_CPID
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic              hreadyout,
	output logic              hresp,
	output logic      [31:0]  hrdata,
	output logic              mem_req,
	output logic              mem_we,
	output logic      [31:0]  mem_addr,
	output logic      [31:0]  mem_wdata,
	input  wire logic         mem_ack,
	input  wire logic [31:0]  mem_rdata,
	input  wire logic         exc_pending,
	output logic              exc_report,
	output logic              proto_viol,
	output logic              busy
);
	fmrm_pkg::fmrm_state_t state;
	fmrm_pkg::fmrm_dec_t   dec;
	fmrm_pkg::fmrm_dec_t   dec_q;

	logic [15:0]      opw;
	logic [15:0]      cmdw;
	logic [31:0]      areg;
	logic [31:0]      dreg;
	logic [31:0]      ea;
	logic             orig;
	logic             done;
	logic             illegal;
	logic             exc_seen;
	logic [2:0]       mask;
	logic [31:0]      addr;
	logic             dp_we;
	logic [7:0]       dp_addr;
	logic [31:0]      rf_rdata;
	logic [2:0][31:0] rf_regs;

	// Register-list walk: the highest select bit is control, so it goes first
	function automatic logic [1:0] fmrm_first(input logic [2:0] m);
		fmrm_first = m[2] ? 2'h0 : (m[1] ? 2'h1 : 2'h2); // [RL3]
	endfunction : fmrm_first

	function automatic logic [2:0] fmrm_bit(input logic [1:0] idx);
		fmrm_bit = 3'h4 >> idx;
	endfunction : fmrm_bit

	// Bus side decode
	wire        ap_valid;
	wire        hi_zero;
	wire        idle;
	wire        wr_ctrl;
	wire        wr_stat;
	wire        start;
	wire        bus_wr_idle;
	wire [31:0] xfer_bytes;
	wire [31:0] rd_mux;
	wire [1:0]  cur_idx;
	wire [2:0]  cur_bit;
	wire        rf_we;
	wire [1:0]  rf_widx;
	wire [31:0] rf_wdata;
	wire        bus_rf_we;
	wire [1:0]  bus_rf_idx;
	wire        seq_rf_we;
	wire [31:0] seq_rf_wdata;
	wire        pick_reg_load;
	wire        rd_reg_store;
	wire        mem_done;
	wire        exc_take;

	assign ap_valid    = hsel && htrans[1] && hready;
	assign hi_zero     = (haddr[31:8] == 24'h000000);
	assign idle        = (state == fmrm_pkg::st_idle);
	assign bus_wr_idle = dp_we && idle;
	assign wr_ctrl     = dp_we && (dp_addr == `FMRM_OFF_CTRL);
	assign wr_stat     = dp_we && (dp_addr == `FMRM_OFF_STAT);
	assign start       = wr_ctrl && idle && hwdata[`FMRM_CTRL_START];
	// Four bytes per register image, since only long words move
	assign xfer_bytes  = {28'h0000000, dec_q.cnt, 2'b00}; // [RL1]

	assign cur_idx = fmrm_first(mask);
	assign cur_bit = fmrm_bit(cur_idx);

	assign bus_rf_idx = (dp_addr == `FMRM_OFF_FPCR) ? 2'h0 :
		(dp_addr == `FMRM_OFF_FPSR) ? 2'h1 :
		(dp_addr == `FMRM_OFF_FPIAR) ? 2'h2 : 2'h3;
	// Software loads of control or status just store; no exception path exists here
	assign bus_rf_we = bus_wr_idle && (bus_rf_idx != 2'h3); // [RL12]

	assign pick_reg_load = (state == fmrm_pkg::st_pick) && (mask != 3'h0)
		&& !dec_q.dir && !dec_q.is_mem;
	assign rd_reg_store  = (state == fmrm_pkg::st_rd) && !dec_q.is_mem;
	assign mem_done      = (state == fmrm_pkg::st_mem) && mem_ack;
	// Variant bit of the starting write governs this move; the stored bit is one write late
	assign exc_take      = start && dec.legal && exc_pending && !hwdata[`FMRM_CTRL_ORIG]; // [RL11]

	assign seq_rf_we    = pick_reg_load || (mem_done && !dec_q.dir); // [RL16]
	assign seq_rf_wdata = (state == fmrm_pkg::st_mem) ? mem_rdata :
		((dec_q.mode == `FMRM_EA_DREG) ? dreg : areg);
	assign rf_we    = seq_rf_we || bus_rf_we;
	assign rf_widx  = seq_rf_we ? cur_idx : bus_rf_idx;
	assign rf_wdata = seq_rf_we ? seq_rf_wdata : hwdata;

	assign rd_mux =
		(haddr[7:0] == `FMRM_OFF_CTRL)  ? {30'h00000000, orig, 1'b0} :
		(haddr[7:0] == `FMRM_OFF_OPW)   ? {16'h0000, opw} :
		(haddr[7:0] == `FMRM_OFF_CMDW)  ? {16'h0000, cmdw} :
		(haddr[7:0] == `FMRM_OFF_AREG)  ? areg :
		(haddr[7:0] == `FMRM_OFF_DREG)  ? dreg :
		(haddr[7:0] == `FMRM_OFF_STAT)  ? {28'h0000000, exc_seen, illegal, done, busy} :
		(haddr[7:0] == `FMRM_OFF_FPCR)  ? rf_regs[0] :
		(haddr[7:0] == `FMRM_OFF_FPSR)  ? rf_regs[1] :
		(haddr[7:0] == `FMRM_OFF_FPIAR) ? rf_regs[2] :
		(haddr[7:0] == `FMRM_OFF_EA)    ? ea : `FMRM_RST_WORD;

	fmrm_decode #(
		.CPID (CPID)
	) u_decode (
		.opw  (opw),
		.cmdw (cmdw),
		.dec  (dec)
	);

	fmrm_ctlregs #(
		.WIDTH (32)
	) u_ctlregs (
		.clk   (clk),
		.rst_n (rst_n),
		.we    (rf_we),
		.widx  (rf_widx),
		.wdata (rf_wdata),
		.ridx  (cur_idx),
		.rdata (rf_rdata),
		.regs  (rf_regs)
	);

	// Zero wait states: every access completes in its first data-phase cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= `FMRM_RST_WORD;
			dp_we     <= 1'b0;
			dp_addr   <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= (ap_valid && !hwrite && hi_zero) ? rd_mux : `FMRM_RST_WORD;
			dp_we     <= ap_valid && hwrite && hi_zero;
			dp_addr   <= ap_valid ? haddr[7:0] : dp_addr;
		end
	end

	// Instruction words are frozen while a move runs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			opw  <= 16'h0000;
			cmdw <= 16'h0000;
			ea   <= `FMRM_RST_WORD;
			orig <= 1'b0;
		end else begin
			if (bus_wr_idle && (dp_addr == `FMRM_OFF_OPW))
				opw <= hwdata[15:0];
			if (bus_wr_idle && (dp_addr == `FMRM_OFF_CMDW))
				cmdw <= hwdata[15:0];
			if (bus_wr_idle && (dp_addr == `FMRM_OFF_EA))
				ea <= hwdata;
			if (wr_ctrl && idle)
				orig <= hwdata[`FMRM_CTRL_ORIG];
		end
	end

	// Address register: predecrement first, postincrement last
	always_ff @(posedge clk) begin
		if (!rst_n)
			areg <= `FMRM_RST_WORD;
		else if (start && dec.legal && dec.predec)
			areg <= areg - {28'h0000000, dec.cnt, 2'b00}; // [RL6]
		else if (rd_reg_store && (dec_q.mode == `FMRM_EA_AREG))
			areg <= rf_rdata; // [RL9]
		else if ((state == fmrm_pkg::st_pick) && (mask == 3'h0) && dec_q.postinc)
			areg <= areg + xfer_bytes; // [RL7]
		else if (bus_wr_idle && (dp_addr == `FMRM_OFF_AREG))
			areg <= hwdata;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			dreg <= `FMRM_RST_WORD;
		else if (rd_reg_store && (dec_q.mode == `FMRM_EA_DREG))
			dreg <= rf_rdata; // [RL8]
		else if (bus_wr_idle && (dp_addr == `FMRM_OFF_DREG))
			dreg <= hwdata;
	end

	// Sticky status; a hardware set in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			done     <= 1'b0;
			illegal  <= 1'b0;
			exc_seen <= 1'b0;
		end else begin
			done     <= (state == fmrm_pkg::st_fin)
				|| (done && !(wr_stat && hwdata[`FMRM_STAT_DONE]));
			illegal  <= (start && !dec.legal)
				|| (illegal && !(wr_stat && hwdata[`FMRM_STAT_ILL]));
			exc_seen <= exc_take
				|| (exc_seen && !(wr_stat && hwdata[`FMRM_STAT_EXC]));
		end
	end

	// Only a bad encoding reports on the original variant
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			exc_report <= 1'b0;
			proto_viol <= 1'b0;
		end else begin
			exc_report <= exc_take; // [RL11]
			proto_viol <= start && !dec.legal; // [RL11] [RL18]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state     <= fmrm_pkg::st_idle;
			dec_q     <= '0;
			mask      <= 3'h0;
			addr      <= `FMRM_RST_WORD;
			busy      <= 1'b0;
			mem_req   <= 1'b0;
			mem_we    <= 1'b0;
			mem_addr  <= `FMRM_RST_WORD;
			mem_wdata <= `FMRM_RST_WORD;
		end else begin
			unique case (state)
				fmrm_pkg::st_idle: begin
					if (start) begin
						dec_q <= dec;
						busy  <= 1'b1;
						mask  <= dec.sel; // [RL2]
						if (!dec.legal)
							state <= fmrm_pkg::st_fin;
						else
							state <= fmrm_pkg::st_pick;
						if (dec.predec)
							addr <= areg - {28'h0000000, dec.cnt, 2'b00}; // [RL6]
						else if (dec.postinc)
							addr <= areg; // [RL7]
						else
							addr <= ea; // [RL5]
					end
				end
				fmrm_pkg::st_pick: begin
					if (mask == 3'h0) begin
						state <= fmrm_pkg::st_fin;
					end else if (dec_q.dir) begin
						state <= fmrm_pkg::st_rd;
					end else if (!dec_q.is_mem) begin
						mask <= mask & ~cur_bit;
					end else begin
						mem_req  <= 1'b1;
						mem_we   <= 1'b0;
						mem_addr <= addr;
						state    <= fmrm_pkg::st_mem;
					end
				end
				fmrm_pkg::st_rd: begin
					if (!dec_q.is_mem) begin
						mask  <= mask & ~cur_bit;
						state <= fmrm_pkg::st_pick;
					end else begin
						mem_req   <= 1'b1;
						mem_we    <= 1'b1;
						mem_addr  <= addr;
						mem_wdata <= rf_rdata; // [RL1]
						state     <= fmrm_pkg::st_mem;
					end
				end
				fmrm_pkg::st_mem: begin
					if (mem_ack) begin
						mem_req <= 1'b0;
						mem_we  <= 1'b0;
						// Skipped registers consume no slot
						addr    <= addr + `FMRM_LONG_BYTES; // [RL4] [RL5]
						mask    <= mask & ~cur_bit; // [RL3]
						state   <= fmrm_pkg::st_pick;
					end
				end
				fmrm_pkg::st_fin: begin
					busy  <= 1'b0;
					state <= fmrm_pkg::st_idle;
				end
				default: begin
					state <= fmrm_pkg::st_idle;
				end
			endcase
		end
	end
endmodule : fmrm_top

/* logic/fmrm_consts.svh */
// Offsets, field positions, reset values and encodings of the control register move block
`ifndef FMRM_CONSTS_SVH
`define FMRM_CONSTS_SVH
`define FMRM_OFF_CTRL    8'h00
`define FMRM_OFF_OPW     8'h04
`define FMRM_OFF_CMDW    8'h08
`define FMRM_OFF_AREG    8'h0C
`define FMRM_OFF_DREG    8'h10
`define FMRM_OFF_STAT    8'h14
`define FMRM_OFF_FPCR    8'h18
`define FMRM_OFF_FPSR    8'h1C
`define FMRM_OFF_FPIAR   8'h20
`define FMRM_OFF_EA      8'h24
`define FMRM_CTRL_START  0
`define FMRM_CTRL_ORIG   1
`define FMRM_STAT_BUSY   0
`define FMRM_STAT_DONE   1
`define FMRM_STAT_ILL    2
`define FMRM_STAT_EXC    3
`define FMRM_RST_WORD    32'h00000000
`define FMRM_LONG_BYTES  32'h00000004
`define FMRM_OP_MARK     4'hF
`define FMRM_OP_ZERO     3'h0
`define FMRM_CMD_MARK    2'h2
`define FMRM_CMD_ZERO    10'h000
`define FMRM_CPID        3'h1
`define FMRM_EA_DREG     3'h0
`define FMRM_EA_AREG     3'h1
`define FMRM_EA_POSTINC  3'h3
`define FMRM_EA_PREDEC   3'h4
`define FMRM_EA_EXT      3'h7
`define FMRM_EXT_ABSW    3'h0
`define FMRM_EXT_ABSL    3'h1
`define FMRM_EXT_PCDISP  3'h2
`define FMRM_EXT_PCIDX   3'h3
`define FMRM_EXT_IMM     3'h4
`define FMRM_SEL_IAR_ONLY 3'h1
`endif

/* logic/fmrm_pkg.sv */
// Types shared by the control register move block
package fmrm_pkg;
	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_pick = 3'b001,
		st_rd   = 3'b010,
		st_mem  = 3'b011,
		st_fin  = 3'b100
	} fmrm_state_t;

	typedef struct packed {
		logic       legal;
		logic       dir;
		logic [2:0] sel;
		logic [1:0] cnt;
		logic [2:0] mode;
		logic       is_mem;
		logic       predec;
		logic       postinc;
	} fmrm_dec_t;
endpackage : fmrm_pkg

/* logic/fmrm_decode.sv */
// Operation and command word decoder with effective address legality check
`timescale 1ns/1ns
`include "fmrm_consts.svh"
module fmrm_decode #(
	parameter logic [2:0] CPID = `FMRM_CPID
) (
	input  wire logic [15:0]       opw,
	input  wire logic [15:0]       cmdw,
	output fmrm_pkg::fmrm_dec_t    dec
);
	wire        op_ok;
	wire        cmd_ok;
	wire [2:0]  sel;
	wire [2:0]  mode;
	wire [2:0]  rg;
	wire        dir;
	wire [1:0]  cnt;
	wire        single;
	wire        ext_ok;
	wire        ea_ok;

	assign op_ok  = (opw[15:12] == `FMRM_OP_MARK) && (opw[11:9] == CPID)
		&& (opw[8:6] == `FMRM_OP_ZERO); // [RL19]
	assign cmd_ok = (cmdw[15:14] == `FMRM_CMD_MARK) && (cmdw[9:0] == `FMRM_CMD_ZERO); // [RL20]
	assign dir    = cmdw[13]; // [RL16]
	assign sel    = cmdw[12:10]; // [RL17]
	assign mode   = opw[5:3];
	assign rg     = opw[2:0];
	assign cnt    = {1'b0, sel[0]} + {1'b0, sel[1]} + {1'b0, sel[2]};
	// One selected register decodes exactly like the single register move
	assign single = (cnt == 2'h1); // [RL10]
	// Immediate and program counter forms only make sense as a source
	assign ext_ok = (rg == `FMRM_EXT_ABSW) || (rg == `FMRM_EXT_ABSL)
		|| (!dir && ((rg == `FMRM_EXT_IMM) || (rg == `FMRM_EXT_PCDISP)
		|| (rg == `FMRM_EXT_PCIDX))); // [RL14] [RL15]
	assign ea_ok  = (mode == `FMRM_EA_DREG) ? single : // [RL8]
		(mode == `FMRM_EA_AREG) ? (sel == `FMRM_SEL_IAR_ONLY) : // [RL9]
		(mode == `FMRM_EA_EXT)  ? ext_ok : 1'b1; // [RL14]

	assign dec.legal   = op_ok && cmd_ok && (sel != 3'h0) && ea_ok; // [RL18]
	assign dec.dir     = dir;
	assign dec.sel     = sel;
	assign dec.cnt     = cnt;
	assign dec.mode    = mode;
	assign dec.is_mem  = (mode != `FMRM_EA_DREG) && (mode != `FMRM_EA_AREG);
	assign dec.predec  = (mode == `FMRM_EA_PREDEC);
	assign dec.postinc = (mode == `FMRM_EA_POSTINC);
endmodule : fmrm_decode

/* logic/fmrm_ctlregs.sv */
// Storage of the three floating-point system control registers
`timescale 1ns/1ns
`include "fmrm_consts.svh"
module fmrm_ctlregs #(
	parameter int WIDTH = 32
) (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   we,
	input  wire logic [1:0]             widx,
	input  wire logic [WIDTH-1:0]       wdata,
	input  wire logic [1:0]             ridx,
	output logic      [WIDTH-1:0]       rdata,
	output logic      [2:0][WIDTH-1:0]  regs
);
	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_reg
			// Whole word replaced, so a status load overwrites every bit
			always_ff @(posedge clk) begin
				if (!rst_n)
					regs[i] <= WIDTH'(`FMRM_RST_WORD);
				else if (we && (widx == 2'(i)))
					regs[i] <= wdata; // [RL13]
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n)
			rdata <= WIDTH'(`FMRM_RST_WORD);
		else
			rdata <= (ridx == 2'h3) ? WIDTH'(`FMRM_RST_WORD) : regs[ridx];
	end
endmodule : fmrm_ctlregs

/* testbench/fmrm_checker_assertions.sv */
// Port assertions for the control register move engine
`timescale 1ns/1ns
module fmrm_checker (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic        mem_ack,
	input wire logic        exc_pending,
	input wire logic        exc_report,
	input wire logic        proto_viol,
	input wire logic        busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic        prev_ok;
	logic [31:0] prev_addr;
	logic        prev_we;
	// Last finished word of the running move; forgotten between moves
	always_ff @(posedge clk) begin
		if (!rst_n || !busy)
			prev_ok <= 1'b0;
		else if (mem_req && mem_ack)
			prev_ok <= 1'b1;
		if (mem_req && mem_ack) begin
			prev_addr <= mem_addr;
			prev_we   <= mem_we;
		end
	end
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus slave not ready or not okay");
	a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata) && $stable(mem_we))
		else $error("memory request changed before ack");
	a_req_drop: assert property (mem_req && mem_ack |=> !mem_req)
		else $error("memory request held after ack");
	a_addr_step: assert property ($rose(mem_req) && prev_ok |-> mem_addr == prev_addr + 32'h00000004)
		else $error("next word not one long word higher");
	a_dir_same: assert property ($rose(mem_req) && prev_ok |-> mem_we == prev_we)
		else $error("direction changed within a move");
	a_idle_quiet: assert property (!busy |-> !mem_req)
		else $error("memory request while idle");
	a_viol_span: assert property (proto_viol |-> busy ##1 !busy)
		else $error("illegal move busy span wrong");
	a_viol_nomem: assert property (proto_viol |-> !mem_req [*3])
		else $error("illegal move touched memory");
	a_exc_cause: assert property (exc_report |-> $past(exc_pending) && !proto_viol ##1 !exc_report)
		else $error("exception report without cause");
	cover property (proto_viol);
	cover property (exc_report);
	cover property ($rose(mem_req) && prev_ok);
endmodule : fmrm_checker
bind fmrm_top fmrm_checker u_fmrm_checker (.clk, .rst_n, .hreadyout, .hresp, .mem_req, .mem_we,
	.mem_addr, .mem_wdata, .mem_ack, .exc_pending, .exc_report, .proto_viol, .busy);

/* testbench/fmrm_mem_model.sv */
// Behavioural memory on the far side of the move engine
`timescale 1ns/1ns
module fmrm_mem_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        slow,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	output logic             mem_ack,
	output logic      [31:0] mem_rdata
);
	logic [31:0] mem [0:255];
	logic [31:0] alog [$];
	logic [1:0]  wcnt;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 32'h00000000;
		wcnt = 2'h0;
		for (int i = 0; i < 256; i++)
			mem[i] = 32'hA5000000 | i;
	end
	// Read data toggles outside the ack cycle so stale data never passes as valid
	always @(posedge clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (!rst_n)
			wcnt <= 2'h0;
		else if (mem_req && !mem_ack) begin
			if (wcnt >= {slow, 1'b0}) begin
				mem_ack <= 1'b1;
				wcnt <= 2'h0;
				alog.push_back(mem_addr);
				if (mem_we)
					mem[mem_addr[9:2]] <= mem_wdata;
				else
					mem_rdata <= mem[mem_addr[9:2]];
			end else
				wcnt <= wcnt + 2'h1;
		end
	end
endmodule : fmrm_mem_model

/* testbench/tb_top.sv */
// Self-checking bench for the control register move engine
`timescale 1ns/1ns
`include "fmrm_consts.svh"
module tb_top;
	logic        clk, rst_n, hsel, hwrite, hready, mem_ack, exc_pending, slow;
	logic        hreadyout, hresp, mem_req, mem_we, exc_report, proto_viol, busy;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, mem_addr, mem_wdata, mem_rdata, rd;
	int          fail_count, checked, cycles, n_exc, n_viol;
	// Single slave: its ready output is the bus ready
	assign hready = hreadyout;
	fmrm_top u_fmrm_top (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hresp, .hrdata, .mem_req, .mem_we, .mem_addr, .mem_wdata,
		.mem_ack, .mem_rdata, .exc_pending, .exc_report, .proto_viol, .busy);
	fmrm_mem_model u_fmrm_mem_model (.clk, .rst_n, .slow, .mem_req, .mem_we, .mem_addr,
		.mem_wdata, .mem_ack, .mem_rdata);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (exc_report === 1'b1) n_exc++;
		if (proto_viol === 1'b1) n_viol++;
		if (cycles == 20000) begin
			fail_count++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h000000, a};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask : bus
	task automatic chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		cmp(what, exp, rd);
	endtask : chk
	function automatic logic [31:0] op(input logic [5:0] ea);
		return {16'h0000, 4'hF, `FMRM_CPID, 3'h0, ea};
	endfunction : op
	function automatic logic [31:0] cm(input logic dir, input logic [2:0] sel);
		return {16'h0000, 2'h2, dir, sel, 10'h000};
	endfunction : cm
	// Start edge is the end of the control write; busy rises at that same edge
	task automatic move(input logic [31:0] o, input logic [31:0] c, input logic orig);
		bus(1'b1, `FMRM_OFF_OPW, o);
		bus(1'b1, `FMRM_OFF_CMDW, c);
		bus(1'b1, `FMRM_OFF_CTRL, {30'h00000000, orig, 1'b1});
		repeat (2) @(posedge clk);
		while (busy !== 1'b0) @(posedge clk);
	endtask : move
	task automatic t_reset();
		chk("fpcr", `FMRM_OFF_FPCR, 32'h00000000);
		chk("fpsr", `FMRM_OFF_FPSR, 32'h00000000);
		chk("stat", `FMRM_OFF_STAT, 32'h00000000);
		bus(1'b1, 8'h80, 32'hFFFFFFFF);
		chk("unmapped", 8'h80, 32'h00000000);
	endtask : t_reset
	task automatic t_load_all();
		slow <= 1'b1;
		bus(1'b1, `FMRM_OFF_EA, 32'h00000040);
		u_fmrm_mem_model.alog.delete();
		move(op(6'h10), cm(1'b0, 3'h7), 1'b0);
		chk("fpcr", `FMRM_OFF_FPCR, 32'hA5000010);
		chk("fpsr", `FMRM_OFF_FPSR, 32'hA5000011);
		chk("fpiar", `FMRM_OFF_FPIAR, 32'hA5000012);
		cmp("last addr", 32'h00000048, u_fmrm_mem_model.alog[2]);
	endtask : t_load_all
	task automatic t_predec();
		slow <= 1'b0;
		bus(1'b1, `FMRM_OFF_AREG, 32'h00000080);
		move(op(6'h20), cm(1'b1, 3'h5), 1'b0);
		chk("areg", `FMRM_OFF_AREG, 32'h00000078);
		cmp("mem 78", 32'hA5000010, u_fmrm_mem_model.mem[30]);
		cmp("mem 7C", 32'hA5000012, u_fmrm_mem_model.mem[31]);
	endtask : t_predec
	task automatic t_postinc();
		bus(1'b1, `FMRM_OFF_AREG, 32'h00000020);
		move(op(6'h18), cm(1'b0, 3'h2), 1'b0);
		chk("fpsr", `FMRM_OFF_FPSR, 32'hA5000008);
		chk("fpcr", `FMRM_OFF_FPCR, 32'hA5000010);
		chk("areg", `FMRM_OFF_AREG, 32'h00000024);
		bus(1'b1, `FMRM_OFF_DREG, 32'h12345678);
		move(op(6'h00), cm(1'b0, 3'h4), 1'b0);
		chk("fpcr dn", `FMRM_OFF_FPCR, 32'h12345678);
		move(op(6'h08), cm(1'b1, 3'h1), 1'b0);
		chk("areg an", `FMRM_OFF_AREG, 32'hA5000012);
	endtask : t_postinc
	task automatic t_illegal();
		logic [31:0] ow [10];
		logic [31:0] cw [10];
		logic        ill [10];
		int          v0;
		ow = '{op(6'h00), op(6'h08), op(6'h3C), op(6'h3A), op(6'h3C), op(6'h3D),
			op(6'h28), op(6'h30), op(6'h10), op(6'h10) | 32'h00000040};
		cw = '{cm(1'b0, 3'h6), cm(1'b1, 3'h4), cm(1'b1, 3'h4), cm(1'b1, 3'h4),
			cm(1'b0, 3'h4), cm(1'b0, 3'h4), cm(1'b0, 3'h1), cm(1'b1, 3'h1),
			cm(1'b0, 3'h0), cm(1'b0, 3'h4)};
		ill = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
		v0 = n_viol;
		for (int i = 0; i < 10; i++) begin
			bus(1'b1, `FMRM_OFF_STAT, 32'h0000000E);
			move(ow[i], cw[i], 1'b0);
			bus(1'b0, `FMRM_OFF_STAT, 32'h00000000);
			cmp("illegal", {29'h0, ill[i], 2'h2}, rd & 32'h00000006);
		end
		move(op(6'h10), cm(1'b0, 3'h4) | 32'h00000001, 1'b0);
		cmp("viol count", 32'd8, n_viol - v0);
	endtask : t_illegal
	task automatic t_exc();
		int e0;
		e0 = n_exc;
		exc_pending <= 1'b1;
		move(op(6'h10), cm(1'b0, 3'h2), 1'b0);
		cmp("exc new", 32'd1, n_exc - e0);
		move(op(6'h10), cm(1'b0, 3'h2), 1'b1);
		cmp("exc orig", 32'd1, n_exc - e0);
		bus(1'b1, `FMRM_OFF_FPCR, 32'h0000FF00);
		bus(1'b1, `FMRM_OFF_FPSR, 32'h0000FF00);
		exc_pending <= 1'b0;
		repeat (2) @(posedge clk);
		cmp("exc write", 32'd1, n_exc - e0);
	endtask : t_exc
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		hsize = 3'h2;
		exc_pending = 1'b0;
		slow = 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_load_all();
		t_predec();
		t_postinc();
		t_illegal();
		t_exc();
		give_verdict();
	end
endmodule : tb_top
